/* File: logic/frac_synth_pkg.sv */
package frac_synth_pkg;

    // Serial word and select codes.
    localparam int word_bits = 24;
    localparam logic [1:0] divider_word_select = 2'h0;
    localparam logic [1:0] refdiv_word_select = 2'h1;
    localparam logic [1:0] control_word_select = 2'h2;
    localparam logic [1:0] noise_word_select = 2'h3;

    // Divider word fields.
    localparam int fast_lock_enable_bit = 23;
    localparam int int_value_msb = 22;
    localparam int int_value_lsb = 14;
    localparam int frac_value_msb = 13;
    localparam int frac_value_lsb = 2;

    // Reference divider word fields.
    localparam int load_control_bit = 23;
    localparam int test_output_select_msb = 22;
    localparam int test_output_select_lsb = 20;
    localparam int prescaler_select_bit = 18;
    localparam int ref_divide_msb = 17;
    localparam int ref_divide_lsb = 14;
    localparam int modulus_msb = 13;
    localparam int modulus_lsb = 2;

    // Control word fields.
    localparam int control_width = 16;
    localparam int counter_reset_bit = 2;
    localparam int charge_pump_tristate_bit = 3;
    localparam int power_down_bit = 4;
    localparam int lock_precision_bit = 5;

    // Noise and spur word.
    localparam int noise_width = 11;
    localparam logic [4:0] lowest_spur_setting = 5'h00;
    localparam logic [4:0] low_noise_spur_setting = 5'h1c;
    localparam logic [4:0] lowest_noise_setting = 5'h1f;

    // Lock detect counts in comparison cycles.
    localparam logic [5:0] lock_count_coarse = 6'h18;
    localparam logic [5:0] lock_count_fine = 6'h28;

    // Values after reset.
    localparam logic [8:0] int_value_reset = 9'h000;
    localparam logic [11:0] field12_reset = 12'h000;
    localparam logic [3:0] ref_divide_reset = 4'h1;
    localparam logic [15:0] control_reset = 16'h0000;
    localparam logic [10:0] noise_reset = 11'h000;

    typedef enum logic [7:0] {
        mux_tristate = 8'h01,
        mux_digital_lock = 8'h02,
        mux_feedback = 8'h04,
        mux_high = 8'h08,
        mux_reference = 8'h10,
        mux_analog_lock = 8'h20,
        mux_fast_lock = 8'h40,
        mux_low = 8'h80
    } test_output_mode_type;

    typedef struct packed {
        logic serial_clock;
        logic serial_data;
        logic latch_strobe;
    } serial_pins_type;

    typedef struct packed {
        logic [8:0] int_value;
        logic [11:0] frac_value;
        logic [11:0] fraction_denominator;
        logic prescaler_select_bit;
        logic [3:0] ref_divide;
    } divide_setting_type;

    typedef struct packed {
        logic error_small;
        logic error_large;
    } phase_error_type;

endpackage

/* File: logic/pin_sync.sv */
`timescale 1ns/1ps

// Two-stage synchroniser; the first stage is read only by the second.
module pin_sync #(
    parameter int width = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Data
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);

    logic [width-1:0] stage_one;
    logic [width-1:0] next_stage_one;
    logic [width-1:0] next_sync_out;

    always_comb
    begin
        next_stage_one = async_in;
        next_sync_out = stage_one;
        if (reset)
        begin
            next_stage_one = '0;
            next_sync_out = '0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        stage_one <= next_stage_one;
        sync_out <= next_sync_out;
    end

endmodule

/* File: logic/tick_divider.sv */
`timescale 1ns/1ps

module tick_divider (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control
    input wire logic hold,
    input wire logic [3:0] ratio,
    // Input edges and divided output
    input wire logic edge_in,
    output logic tick,
    output logic div_out
);

    logic [3:0] count;
    logic [3:0] next_count;
    logic next_tick;
    logic next_div_out;
    logic [3:0] limit;

    // A ratio of zero is outside the valid range and behaves as one.
    assign limit = (ratio == 4'h0) ? 4'h1 : ratio;

    always_comb
    begin
        next_count = count;
        next_tick = 1'b0;
        next_div_out = div_out;
        if (reset || hold)
        begin
            next_count = 4'h0;
            next_div_out = 1'b0;
        end
        else if (edge_in)
        begin
            if (count + 4'h1 >= limit)
            begin
                next_count = 4'h0;
                next_tick = 1'b1;
                next_div_out = ~div_out;
            end
            else
            begin
                next_count = count + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        count <= next_count;
        tick <= next_tick;
        div_out <= next_div_out;
    end

endmodule

/* File: logic/frac_synth_program_registers.sv */
`timescale 1ns/1ps

// Notes on behaviour
// - Words are 24 bits, MSB first on rising serial clock, latched on strobe rise.
// - Select 00 loads the divider word, 01 the reference divider word.
// - Select 11 loads the noise and spur word.
// - Divider word holds nine-bit integer and twelve-bit fraction for feedback division.
// - Fast-lock enable bit starts fast lock using the loaded timer value.
// - Fast lock drives sixteen times charge pump current, then one times after expiry.
// - Wide bandwidth lasts the timer count in comparison cycles.
// - Load control bit picks denominator or fast-lock timer for bits 13 to 2.
// - New denominator takes effect only at the next divider word write.
// - Prescaler bit selects 4/5 at 0, 8/9 at 1; host picks 8/9 above 2 GHz.
// - Four-bit reference ratio divides the reference input, ratios 1 to 15.
// - Three-bit select routes lock, dividers, levels or fast-lock switch to test pin.
// - Digital lock sets after 24 or 40 consecutive cycles with error under 15 ns.
// - Lock holds until a new channel or an error above 30 ns.
// - Lock precision bit chooses 24 cycles at 0 and 40 cycles at 1.
// - Control bit 2 holds the counters in reset.
// - Control bit 3 puts the charge pump in high impedance.
// - Control bit 4 powers down; clearing it restores operation.
// - Power-down loads counters, three-states the pump and resets lock detect.
// - Power-down keeps all registers and leaves the serial input working.
// - Noise bits 9,8,7,6,2 pick lowest spur, low noise and spur, lowest noise.
module frac_synth_program_registers (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Serial programming pins
    input wire frac_synth_pkg::serial_pins_type serial_pins,
    // Reference input and divided feedback edges
    input wire logic reference_input,
    input wire logic feedback_input,
    // Phase detector error flags, one sample per comparison cycle
    input wire frac_synth_pkg::phase_error_type phase_error,
    // Programmed division, control and noise words
    output frac_synth_pkg::divide_setting_type divide_setting,
    output logic [15:0] control_word,
    output logic [10:0] noise_spur_word,
    output logic dither_enable,
    // Loop state
    output logic counters_reset,
    output logic power_down,
    output logic charge_pump_tristate,
    output logic charge_pump_gain_16x,
    output logic digital_lock,
    // Test output pin
    output logic test_output,
    output logic test_output_oe
);
    import frac_synth_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edges.

    serial_pins_type pins_sync;
    logic [1:0] clocks_sync;
    logic [1:0] errors_sync;
    logic sclk_prev;
    logic latch_prev;
    logic ref_prev;
    logic sclk_rise;
    logic latch_rise;
    logic ref_rise;

    pin_sync #(.width(3)) serial_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async_in(serial_pins),
        .sync_out(pins_sync)
    );

    pin_sync #(.width(4)) loop_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async_in({reference_input, feedback_input, phase_error.error_small, phase_error.error_large}),
        .sync_out({clocks_sync, errors_sync})
    );

    assign sclk_rise = pins_sync.serial_clock && !sclk_prev;
    assign latch_rise = pins_sync.latch_strobe && !latch_prev;
    assign ref_rise = clocks_sync[1] && !ref_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // Shift register and register bank.

    logic [23:0] shift_reg;
    logic [11:0] pending_denominator;
    logic [11:0] fast_lock_timer;
    logic fast_lock_enable_bit;
    logic [2:0] test_output_select;
    logic new_channel;
    logic [23:0] next_shift_reg;
    logic [11:0] next_pending_denominator;
    logic [11:0] next_fast_lock_timer;
    logic next_fast_lock_enable_bit;
    logic [2:0] next_test_output_select;
    divide_setting_type next_divide_setting;
    logic [15:0] next_control_word;
    logic [10:0] next_noise_spur_word;
    logic next_new_channel;

    // The serial input stays live in power-down, so nothing here looks at it.
    always_comb
    begin
        next_shift_reg = shift_reg;
        next_pending_denominator = pending_denominator;
        next_fast_lock_timer = fast_lock_timer;
        next_fast_lock_enable_bit = fast_lock_enable_bit;
        next_test_output_select = test_output_select;
        next_divide_setting = divide_setting;
        next_control_word = control_word;
        next_noise_spur_word = noise_spur_word;
        next_new_channel = 1'b0;
        if (sclk_rise)
        begin
            next_shift_reg = {shift_reg[22:0], pins_sync.serial_data};
        end
        if (latch_rise)
        begin
            unique case (shift_reg[1:0])
                divider_word_select:
                begin
                    next_divide_setting.int_value = shift_reg[int_value_msb:int_value_lsb];
                    next_divide_setting.frac_value = shift_reg[frac_value_msb:frac_value_lsb];
                    next_divide_setting.fraction_denominator = pending_denominator;
                    next_fast_lock_enable_bit = shift_reg[frac_synth_pkg::fast_lock_enable_bit];
                    next_new_channel = 1'b1;
                end
                refdiv_word_select:
                begin
                    if (shift_reg[load_control_bit])
                    begin
                        next_fast_lock_timer = shift_reg[modulus_msb:modulus_lsb];
                    end
                    else
                    begin
                        next_pending_denominator = shift_reg[modulus_msb:modulus_lsb];
                    end
                    next_test_output_select = shift_reg[test_output_select_msb:test_output_select_lsb];
                    next_divide_setting.prescaler_select_bit = shift_reg[prescaler_select_bit];
                    next_divide_setting.ref_divide = shift_reg[ref_divide_msb:ref_divide_lsb];
                end
                control_word_select: next_control_word = shift_reg[control_width-1:0];
                noise_word_select: next_noise_spur_word = shift_reg[noise_width-1:0];
            endcase
        end
        if (reset)
        begin
            next_shift_reg = '0;
            next_pending_denominator = field12_reset;
            next_fast_lock_timer = field12_reset;
            next_fast_lock_enable_bit = 1'b0;
            next_test_output_select = 3'h0;
            next_divide_setting = {int_value_reset, field12_reset, field12_reset, 1'b0, ref_divide_reset};
            next_control_word = control_reset;
            next_noise_spur_word = noise_reset;
            next_new_channel = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        shift_reg <= next_shift_reg;
        sclk_prev <= reset ? 1'b0 : pins_sync.serial_clock;
        latch_prev <= reset ? 1'b0 : pins_sync.latch_strobe;
        ref_prev <= reset ? 1'b0 : clocks_sync[1];
        pending_denominator <= next_pending_denominator;
        fast_lock_timer <= next_fast_lock_timer;
        fast_lock_enable_bit <= next_fast_lock_enable_bit;
        test_output_select <= next_test_output_select;
        divide_setting <= next_divide_setting;
        control_word <= next_control_word;
        noise_spur_word <= next_noise_spur_word;
        new_channel <= next_new_channel;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reference divider, fast lock, lock detect and test output.

    logic pfd_tick;
    logic ref_div_out;
    logic [11:0] fast_lock_count;
    logic [5:0] lock_count;
    logic [5:0] lock_target;
    logic [4:0] noise_setting;
    test_output_mode_type mux_mode;
    logic [11:0] next_fast_lock_count;
    logic next_gain_16x;
    logic [5:0] next_lock_count;
    logic next_digital_lock;
    logic next_test_output;
    logic next_test_output_oe;

    tick_divider reference_divider (
        .core_clk(core_clk),
        .reset(reset),
        .hold(counters_reset),
        .ratio(divide_setting.ref_divide),
        .edge_in(ref_rise),
        .tick(pfd_tick),
        .div_out(ref_div_out)
    );

    assign lock_target = control_word[lock_precision_bit] ? lock_count_fine : lock_count_coarse;
    assign noise_setting = {noise_spur_word[9:6], noise_spur_word[2]};
    assign mux_mode = test_output_mode_type'(8'h01 << test_output_select);

    always_comb
    begin
        next_fast_lock_count = fast_lock_count;
        next_gain_16x = charge_pump_gain_16x;
        next_lock_count = lock_count;
        next_digital_lock = digital_lock;
        // A new channel starts the wide-bandwidth interval from the loaded timer.
        if (new_channel && fast_lock_enable_bit && fast_lock_timer != 12'h000)
        begin
            next_fast_lock_count = fast_lock_timer;
            next_gain_16x = 1'b1;
        end
        else if (charge_pump_gain_16x && pfd_tick)
        begin
            next_fast_lock_count = fast_lock_count - 12'h001;
            if (fast_lock_count == 12'h001)
            begin
                next_gain_16x = 1'b0;
            end
        end
        if (new_channel || (pfd_tick && errors_sync[0]))
        begin
            next_lock_count = 6'h00;
            next_digital_lock = 1'b0;
        end
        else if (pfd_tick)
        begin
            if (errors_sync[1])
            begin
                next_lock_count = (lock_count < lock_target) ? lock_count + 6'h01 : lock_count;
                if (lock_count + 6'h01 >= lock_target)
                begin
                    next_digital_lock = 1'b1;
                end
            end
            else
            begin
                // Between the two windows the run restarts but an existing lock holds.
                next_lock_count = 6'h00;
            end
        end
        if (reset || control_word[power_down_bit])
        begin
            next_fast_lock_count = 12'h000;
            next_gain_16x = 1'b0;
            next_lock_count = 6'h00;
            next_digital_lock = 1'b0;
        end
    end

    always_comb
    begin
        next_test_output_oe = 1'b1;
        unique case (mux_mode)
            mux_tristate:
            begin
                next_test_output = 1'b0;
                next_test_output_oe = 1'b0;
            end
            mux_digital_lock: next_test_output = digital_lock;
            mux_feedback: next_test_output = clocks_sync[0] && !counters_reset;
            mux_high: next_test_output = 1'b1;
            mux_reference: next_test_output = ref_div_out;
            mux_analog_lock: next_test_output = digital_lock;
            mux_fast_lock: next_test_output = charge_pump_gain_16x;
            mux_low: next_test_output = 1'b0;
        endcase
        if (reset)
        begin
            next_test_output = 1'b0;
            next_test_output_oe = 1'b0;
        end
    end

    // Power-down forces the counters to load and the pump to three-state.
    always_ff @(posedge core_clk)
    begin
        fast_lock_count <= next_fast_lock_count;
        charge_pump_gain_16x <= next_gain_16x;
        lock_count <= next_lock_count;
        digital_lock <= next_digital_lock;
        test_output <= next_test_output;
        test_output_oe <= next_test_output_oe;
        counters_reset <= !reset && (control_word[counter_reset_bit] || control_word[power_down_bit]);
        charge_pump_tristate <= !reset && (control_word[charge_pump_tristate_bit] || control_word[power_down_bit]);
        power_down <= !reset && control_word[power_down_bit];
        dither_enable <= !reset && (noise_setting == lowest_spur_setting);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence s_divider_latch;
        latch_rise && shift_reg[1:0] == divider_word_select;
    endsequence

    property p_divider_load;
        @(posedge core_clk) disable iff (reset)
        s_divider_latch |=> divide_setting.int_value == $past(shift_reg[22:14])
            && divide_setting.frac_value == $past(shift_reg[13:2]);
    endproperty
    a_divider_load: assert property (p_divider_load) else $error("divider word not loaded");

    property p_denominator_buffered;
        @(posedge core_clk) disable iff (reset)
        latch_rise && shift_reg[1:0] == refdiv_word_select && !shift_reg[23]
            |=> pending_denominator == $past(shift_reg[13:2]) && $stable(divide_setting.fraction_denominator);
    endproperty
    a_denominator_buffered: assert property (p_denominator_buffered) else $error("denominator not buffered");

    property p_timer_load;
        @(posedge core_clk) disable iff (reset)
        latch_rise && shift_reg[1:0] == refdiv_word_select && shift_reg[23]
            |=> fast_lock_timer == $past(shift_reg[13:2]) && $stable(pending_denominator);
    endproperty
    a_timer_load: assert property (p_timer_load) else $error("fast-lock timer not loaded");

    property p_denominator_apply;
        @(posedge core_clk) disable iff (reset)
        s_divider_latch |=> divide_setting.fraction_denominator == $past(pending_denominator);
    endproperty
    a_denominator_apply: assert property (p_denominator_apply) else $error("denominator not applied");

    property p_control_noise;
        @(posedge core_clk) disable iff (reset)
        latch_rise && shift_reg[1] |=> (control_word == $past(shift_reg[15:0])) != (noise_spur_word == $past(shift_reg[10:0]))
            || $past(shift_reg[15:0]) == control_word;
    endproperty
    a_control_noise: assert property (p_control_noise) else $error("control or noise word not loaded");

    property p_power_down;
        @(posedge core_clk) disable iff (reset)
        control_word[power_down_bit] |=> !digital_lock && charge_pump_tristate && counters_reset;
    endproperty
    a_power_down: assert property (p_power_down) else $error("power-down effects missing");

    property p_lock_loss;
        @(posedge core_clk) disable iff (reset)
        pfd_tick && errors_sync[0] |=> !digital_lock && lock_count == 6'h00;
    endproperty
    a_lock_loss: assert property (p_lock_loss) else $error("lock held through large error");

    property p_lock_count;
        @(posedge core_clk) disable iff (reset)
        $rose(digital_lock) |-> $past(lock_count) + 6'h01 >= $past(lock_target);
    endproperty
    a_lock_count: assert property (p_lock_count) else $error("lock set too early");

    property p_fast_lock_end;
        @(posedge core_clk) disable iff (reset)
        charge_pump_gain_16x && pfd_tick && fast_lock_count == 12'h001 && !new_channel |=> !charge_pump_gain_16x;
    endproperty
    a_fast_lock_end: assert property (p_fast_lock_end) else $error("fast lock overran timer");

    property p_mux_high;
        @(posedge core_clk) disable iff (reset)
        test_output_select == 3'h3 |=> test_output && test_output_oe;
    endproperty
    a_mux_high: assert property (p_mux_high) else $error("test output not high");

endmodule

/* File: testbench/serial_host.sv */
`timescale 1ns/1ps

module serial_host (
    // Clock
    input wire logic core_clk,
    // Serial pins
    output frac_synth_pkg::serial_pins_type pins
);
    import frac_synth_pkg::*;

    initial pins = '0;

    // Every level stands four core clocks so the two-flop synchronisers never miss it.
    task automatic hold_pin();
        repeat (4) @(negedge core_clk);
    endtask

    task automatic send_word(input logic [23:0] word);
        for (int i = 23; i >= 0; i--)
        begin
            pins.serial_data = word[i];
            hold_pin();
            pins.serial_clock = 1'b1;
            hold_pin();
            pins.serial_clock = 1'b0;
        end
        hold_pin();
        pins.latch_strobe = 1'b1;
        pins.serial_data = ~word[0];
        hold_pin();
        pins.latch_strobe = 1'b0;
        hold_pin();
    endtask
endmodule

/* File: testbench/tb_frac_synth_program_registers.sv */
`timescale 1ns/1ps

module tb_frac_synth_program_registers;
    import frac_synth_pkg::*;

    typedef struct packed {logic [2:0] sel; logic [37:0] val;} note_type;

    logic core_clk, reset, reference_input, dth, ps;
    logic dither_enable, counters_reset, power_down, charge_pump_tristate;
    logic charge_pump_gain_16x, digital_lock, test_output, test_output_oe;
    logic [15:0] control_word;
    logic [10:0] noise_spur_word;
    logic [11:0] pend, d;
    phase_error_type phase_error;
    serial_pins_type serial_pins;
    divide_setting_type divide_setting, model;
    note_type notes[$];
    note_type n;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    serial_host u_host (.core_clk, .pins(serial_pins));

    frac_synth_program_registers u_dut (.core_clk, .reset, .serial_pins, .reference_input,
        .feedback_input(1'b0), .phase_error, .divide_setting, .control_word, .noise_spur_word,
        .dither_enable, .counters_reset, .power_down, .charge_pump_tristate, .charge_pump_gain_16x,
        .digital_lock, .test_output, .test_output_oe);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [37:0] seen(input logic [2:0] sel);
        case (sel)
            3'h0: return divide_setting;
            3'h1: return 38'(control_word[15:2]);
            3'h2: return 38'(noise_spur_word[10:2]);
            3'h3: return 38'({power_down, counters_reset, charge_pump_tristate, dither_enable});
            3'h4: return 38'(digital_lock);
            3'h5: return 38'(charge_pump_gain_16x);
            3'h6: return 38'({test_output_oe, test_output});
            default: return 38'(test_output_oe);
        endcase
    endfunction

    task automatic check(input logic [37:0] got, input logic [37:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Outputs are read half a period after the launching edge, when they have settled.
    always @(negedge core_clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            failures++;
            complete_run();
        end
        else
            while (notes.size() > 0)
            begin
                n = notes.pop_front();
                check(seen(n.sel), n.val);
            end
    end

    task automatic note(input logic [2:0] sel, input logic [37:0] val);
        notes.push_back({sel, val});
    endtask

    task automatic ticks(input int k);
        repeat (k)
        begin
            reference_input = 1'b1;
            repeat (5) @(negedge core_clk);
            reference_input = 1'b0;
            repeat (5) @(negedge core_clk);
        end
    endtask

    task automatic wr_div(input logic fl, input logic [8:0] iv, input logic [11:0] fv);
        u_host.send_word({fl, iv, fv, divider_word_select});
        model.int_value = iv;
        model.frac_value = fv;
        model.fraction_denominator = pend;
        note(3'h0, model);
    endtask

    task automatic wr_ref(input logic lc, input logic [2:0] mx, input logic [3:0] r, input logic [11:0] m);
        u_host.send_word({lc, mx, 1'b0, ps, r, m, refdiv_word_select});
        if (!lc)
            pend = m;
        model.prescaler_select_bit = ps;
        model.ref_divide = r;
        note(3'h0, model);
    endtask

    task automatic wr_ctl(input logic [3:0] b);
        u_host.send_word({18'h00000, b, control_word_select});
        note(3'h1, 38'({10'h000, b}));
        note(3'h3, 38'({b[2], b[0] | b[2], b[1] | b[2], dth}));
    endtask

    task automatic wr_noise(input logic [4:0] s);
        u_host.send_word({14'h0000, s[4:1], 3'h0, s[0], noise_word_select});
        dth = (s == lowest_spur_setting);
        note(3'h2, 38'({1'b0, s[4:1], 3'h0, s[0]}));
        note(3'h3, 38'({3'h0, dth}));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        reset = 1'b1;
        reference_input = 1'b0;
        phase_error = '0;
        model = '0;
        model.ref_divide = ref_divide_reset;
        pend = '0;
        dth = 1'b0;
        ps = 1'b0;
        void'($urandom(22));
        repeat (10) @(negedge core_clk);
        reset = 1'b0;
        @(negedge core_clk);
        note(3'h0, model);
        note(3'h6, 38'h0);
        wr_noise(low_noise_spur_setting);
        wr_noise(lowest_noise_setting);
        wr_noise(lowest_spur_setting);
        $display("test noise done");
        for (int i = 0; i < 5; i++)
            wr_ctl(4'(5'h01 << i));
        $display("test control done");
        // New denominator must stay hidden until the divider word follows.
        repeat (3)
        begin
            ps = 1'($urandom);
            d = 12'($urandom_range(4095, 2));
            wr_ref(1'b0, 3'h0, 4'($urandom_range(15, 1)), d);
            wr_div(1'b0, 9'($urandom_range(511, ps ? 91 : 31)), 12'($urandom_range(d - 1, 0)));
        end
        $display("test dividers done");
        for (int m = 0; m < 8; m++)
        begin
            wr_ref(1'b0, 3'(m), model.ref_divide, pend);
            note(3'h7, 38'(m != 0));
            if (m == 1 || m == 3 || m == 7)
                note(3'h6, {37'h1, m == 3});
        end
        $display("test test pin done");
        wr_ref(1'b0, 3'h1, 4'h1, pend);
        phase_error = 2'b10;
        ticks(23);
        note(3'h4, 38'h0);
        ticks(1);
        note(3'h4, 38'h1);
        note(3'h6, 38'h3);
        phase_error = 2'b00;
        ticks(3);
        note(3'h4, 38'h1);
        phase_error = 2'b01;
        ticks(1);
        note(3'h4, 38'h0);
        wr_ctl(4'h8);
        phase_error = 2'b10;
        ticks(39);
        note(3'h4, 38'h0);
        ticks(1);
        note(3'h4, 38'h1);
        wr_ctl(4'hc);
        note(3'h4, 38'h0);
        wr_div(1'b0, model.int_value, model.frac_value);
        wr_ctl(4'h0);
        $display("test lock done");
        phase_error = 2'b00;
        wr_ref(1'b1, 3'h6, 4'h1, 12'h003);
        wr_div(1'b1, model.int_value, model.frac_value);
        note(3'h5, 38'h1);
        ticks(2);
        note(3'h5, 38'h1);
        ticks(1);
        note(3'h5, 38'h0);
        $display("test fast lock done");
        repeat (2) @(negedge core_clk);
        complete_run();
    end
endmodule
